// File: rtl/stsr_cfg.svh
// Constants of the status-read command handler: codes, offsets, layout.
// Assumes inclusion by every design file that needs a number.
`ifndef STSR_CFG_SVH
`define STSR_CFG_SVH

// ****************************************
// Control characters and command letters
// ****************************************
`define STSR_ENQ 8'h05
`define STSR_EOT 8'h04
`define STSR_ACK 8'h06
`define STSR_NAK 8'h15
`define STSR_ETX 8'h03
`define STSR_CMD_UP 8'h52
`define STSR_CMD_LO 8'h72
`define STSR_TYPE_HI 8'h53
`define STSR_TYPE_LO 8'h54

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define STSR_OFS_CTRL 5'h00
`define STSR_OFS_STN 5'h04
`define STSR_OFS_INFO 5'h08
`define STSR_OFS_MODE 5'h0C
`define STSR_OFS_ERR 5'h10
`define STSR_OFS_STAT 5'h14

// ****************************************
// Reset values and field positions
// ****************************************
`define STSR_CTRL_RST 2'h1
`define STSR_CTRL_EN 0
`define STSR_CTRL_FNAK 1
`define STSR_CONN_LSB 8
`define STSR_ERR_RST 16'h0000

// ****************************************
// Reply layout
// ****************************************
`define STSR_PAY_IDX 6'h06
`define STSR_REC_CHARS 6'h28
`define STSR_ERR_CHARS 6'h04
`define STSR_POS_TYPE 5'h02
`define STSR_POS_VER 5'h04
`define STSR_POS_MODE 5'h05
`define STSR_POS_CONN 5'h07

`endif

// File: rtl/stsr_pkg.sv
// Types shared by the status-read command handler.
// Assumes nothing of its surroundings.
`default_nettype none

package stsr_pkg;
    // Receive parser states
    typedef enum logic [3:0] {
        RX_IDLE, RX_STN_H, RX_STN_L, RX_CMD, RX_TY_H, RX_TY_L, RX_EOT, RX_CK_H, RX_CK_L
    } stsr_rx_t;
endpackage : stsr_pkg

`default_nettype wire

// File: rtl/stsr_bcc.sv
// Running byte sum used for the frame checksum.
// Assumes a synchronous clear that may coincide with the first byte.
`default_nettype none

module stsr_cksum (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Control
    input wire logic clr,
    input wire logic add,
    input wire logic [7:0] byte_in,
    // Result
    output logic [7:0] sum
);
    logic [7:0] sum_ff;
    logic [7:0] nxt_sum;

    // ****************************************
    // Accumulator
    // ****************************************
    // Clear restarts with the byte that arrives in the same cycle
    assign nxt_sum = clr ? (add ? byte_in : 8'h00) : (add ? sum_ff + byte_in : sum_ff);
    assign sum = sum_ff;

    // Low byte only; carries are dropped on purpose
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sum_ff <= 8'h00;
        end else begin
            sum_ff <= nxt_sum;
        end
    end
endmodule : stsr_cksum

`default_nettype wire

// File: rtl/stsr_top.sv
// Status-read command handler: parses request frames, sends ACK/NAK replies.
// Assumes byte streams from and to a UART with valid/ready handshakes.
//
// The Avalon-MM register port and the address map were left to the implementer.
`include "stsr_cfg.svh"
`default_nettype none

module stsr_top #(
    parameter logic [7:0] CPU_TYPE_RST = 8'h5A, // Arbitrary value
    parameter logic [7:0] VER_RST = 8'h10
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Received bytes
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    // Transmitted bytes
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready
);
    import stsr_pkg::*;

    // ****************************************
    // Helpers
    // ****************************************
    // Nibble to upper-case ASCII hex
    function automatic logic [7:0] nib2hex(input logic [3:0] n);
        nib2hex = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
    endfunction : nib2hex

    // ASCII hex to {valid, nibble}; both letter cases accepted
    function automatic logic [4:0] hex2nib(input logic [7:0] c);
        if (c >= 8'h30 && c <= 8'h39) hex2nib = {1'b1, c[3:0]};
        else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
            hex2nib = {1'b1, c[3:0] + 4'h9};
        else hex2nib = 5'h00;
    endfunction : hex2nib

    // Byte-lane merge for writes
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] be);
        for (int i = 0; i < 4; i++) merge[i*8 +: 8] = be[i] ? n[i*8 +: 8] : o[i*8 +: 8];
    endfunction : merge

    // ****************************************
    // Reset synchroniser
    // ****************************************
    logic rst_meta_ff;
    logic rst_n; // Synchronised reset used everywhere else

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_meta_ff <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n <= rst_meta_ff;
        end
    end

    // ****************************************
    // Register file
    // ****************************************
    logic [1:0] ctrl_ff; // Enable, force NAK
    logic [7:0] stn_ff; // Own station number
    logic [15:0] info_ff; // {version, CPU type}
    logic [9:0] mode_ff; // [1:0] mode select, [9:8] connection
    logic [15:0] err_ff; // Error code sent in NAK
    logic [15:0] cnt_ff; // Replies started
    logic ack_ff; // Bus answer pulse
    logic [31:0] rdat_ff;
    logic tx_busy_ff;
    wire req = avs_read | avs_write;
    wire wr_go = avs_write & ack_ff;
    wire [31:0] stat_w = {15'h0000, tx_busy_ff, cnt_ff};
    // Unmapped reads return zero
    wire [31:0] rd_mux =
        (avs_address == `STSR_OFS_CTRL) ? {30'h00000000, ctrl_ff} :
        (avs_address == `STSR_OFS_STN) ? {24'h000000, stn_ff} :
        (avs_address == `STSR_OFS_INFO) ? {16'h0000, info_ff} :
        (avs_address == `STSR_OFS_MODE) ? {22'h000000, mode_ff} :
        (avs_address == `STSR_OFS_ERR) ? {16'h0000, err_ff} :
        (avs_address == `STSR_OFS_STAT) ? stat_w : 32'h00000000;
    wire [31:0] wm_ctrl = merge({30'h00000000, ctrl_ff}, avs_writedata, avs_byteenable);
    wire [31:0] wm_stn = merge({24'h000000, stn_ff}, avs_writedata, avs_byteenable);
    wire [31:0] wm_info = merge({16'h0000, info_ff}, avs_writedata, avs_byteenable);
    wire [31:0] wm_mode = merge({22'h000000, mode_ff}, avs_writedata, avs_byteenable);
    wire [31:0] wm_err = merge({16'h0000, err_ff}, avs_writedata, avs_byteenable);

    // One wait cycle per access, then the answer
    assign avs_waitrequest = req & ~ack_ff;
    assign avs_readdata = rdat_ff;

    // Answer strobe and read data
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack_ff <= 1'b0;
            rdat_ff <= 32'h00000000;
        end else begin
            ack_ff <= req & ~ack_ff;
            rdat_ff <= rd_mux;
        end
    end

    // Writable registers; unmapped writes are dropped
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= `STSR_CTRL_RST;
            stn_ff <= 8'h00;
            info_ff <= {VER_RST, CPU_TYPE_RST};
            mode_ff <= 10'h000;
            err_ff <= `STSR_ERR_RST;
        end else if (wr_go) begin
            if (avs_address == `STSR_OFS_CTRL) ctrl_ff <= wm_ctrl[1:0];
            if (avs_address == `STSR_OFS_STN) stn_ff <= wm_stn[7:0];
            if (avs_address == `STSR_OFS_INFO) info_ff <= wm_info[15:0];
            if (avs_address == `STSR_OFS_MODE) mode_ff <= wm_mode[9:0];
            if (avs_address == `STSR_OFS_ERR) err_ff <= wm_err[15:0];
        end
    end

    // ****************************************
    // Request parser
    // ****************************************
    stsr_rx_t rx_st_ff, nxt_rx_st;
    logic stn_ok_ff; // Station chars matched so far
    logic lower_ff; // Lowercase command seen
    logic [3:0] ck_hi_ff; // First checksum nibble
    logic ck_ok_ff; // First checksum char was hex
    logic [7:0] rx_sum;
    logic tx_valid_ff;
    logic [7:0] tx_data_ff;
    wire rx_take = rx_valid & rx_ready;
    wire is_enq = rx_data == `STSR_ENQ;
    wire [4:0] rx_hex = hex2nib(rx_data);
    wire stn_hit_h = rx_hex[4] & (rx_hex[3:0] == stn_ff[7:4]);
    wire stn_hit_l = rx_hex[4] & (rx_hex[3:0] == stn_ff[3:0]);
    // ENQ always opens a new sum, even where it cuts a checksum pair short
    wire adding = rx_take & (is_enq | ((rx_st_ff != RX_CK_H) & (rx_st_ff != RX_CK_L) &
                  (rx_st_ff != RX_IDLE)));
    wire eot_end = rx_take & (rx_st_ff == RX_EOT) & (rx_data == `STSR_EOT);
    wire rx_eof = (eot_end & ~lower_ff) | (rx_take & (rx_st_ff == RX_CK_L));
    // Compare received checksum with the sum held since EOT
    wire sum_ok = ~lower_ff | (ck_ok_ff & rx_hex[4] & ({ck_hi_ff, rx_hex[3:0]} == rx_sum));
    wire reply_go = rx_eof & stn_ok_ff & ctrl_ff[`STSR_CTRL_EN];
    wire nak_now = ctrl_ff[`STSR_CTRL_FNAK] | ~sum_ok;

    // Accept only while no reply is pending
    assign rx_ready = ~tx_busy_ff & ~tx_valid_ff;

    stsr_cksum u_rx_cksum (
        .clock(clock),
        .rst_n(rst_n),
        .clr(rx_take & is_enq),
        .add(adding),
        .byte_in(rx_data),
        .sum(rx_sum)
    );

    // Next state; a stray byte before the checksum drops the frame, ENQ restarts it
    always_comb begin
        nxt_rx_st = rx_st_ff;
        if (rx_take) begin
            unique case (rx_st_ff)
                RX_IDLE: nxt_rx_st = is_enq ? RX_STN_H : RX_IDLE;
                RX_STN_H: nxt_rx_st = rx_hex[4] ? RX_STN_L : RX_IDLE;
                RX_STN_L: nxt_rx_st = rx_hex[4] ? RX_CMD : RX_IDLE;
                RX_CMD: begin
                    nxt_rx_st = (rx_data == `STSR_CMD_UP || rx_data == `STSR_CMD_LO) ?
                                RX_TY_H : RX_IDLE;
                end
                RX_TY_H: nxt_rx_st = (rx_data == `STSR_TYPE_HI) ? RX_TY_L : RX_IDLE;
                RX_TY_L: nxt_rx_st = (rx_data == `STSR_TYPE_LO) ? RX_EOT : RX_IDLE;
                RX_EOT: begin
                    nxt_rx_st = (rx_data != `STSR_EOT) ? RX_IDLE :
                                (lower_ff ? RX_CK_H : RX_IDLE);
                end
                RX_CK_H: nxt_rx_st = RX_CK_L;
                RX_CK_L: nxt_rx_st = RX_IDLE;
            endcase
            if (is_enq) nxt_rx_st = RX_STN_H;
        end
    end

    // Parser state and frame attributes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_st_ff <= RX_IDLE;
            stn_ok_ff <= 1'b0;
            lower_ff <= 1'b0;
            ck_hi_ff <= 4'h0;
            ck_ok_ff <= 1'b0;
        end else begin
            rx_st_ff <= nxt_rx_st;
            if (rx_take && rx_st_ff == RX_STN_H) stn_ok_ff <= stn_hit_h;
            if (rx_take && rx_st_ff == RX_STN_L) stn_ok_ff <= stn_ok_ff & stn_hit_l;
            if (rx_take && rx_st_ff == RX_CMD) lower_ff <= rx_data == `STSR_CMD_LO;
            if (rx_take && rx_st_ff == RX_CK_H) begin
                ck_hi_ff <= rx_hex[3:0];
                ck_ok_ff <= rx_hex[4];
            end
        end
    end

    // ****************************************
    // Reply generator
    // ****************************************
    logic nak_ff; // Reply is NAK
    logic [5:0] idx_ff; // Next byte position
    logic [7:0] tx_sum;
    wire [5:0] etx_idx = `STSR_PAY_IDX + (nak_ff ? `STSR_ERR_CHARS : `STSR_REC_CHARS);
    wire [5:0] last_idx = lower_ff ? etx_idx + 6'h02 : etx_idx;
    wire [5:0] pidx = idx_ff - `STSR_PAY_IDX;
    wire [7:0] mode_b = 8'h02 << mode_ff[1:0];
    wire [7:0] conn_b = {6'h00, mode_ff[`STSR_CONN_LSB +: 2]};
    // Record byte selected by payload position; unused bytes are zero
    wire [7:0] rec_b =
        (pidx[5:1] == `STSR_POS_TYPE) ? info_ff[7:0] :
        (pidx[5:1] == `STSR_POS_VER) ? info_ff[15:8] :
        (pidx[5:1] == `STSR_POS_MODE) ? mode_b :
        (pidx[5:1] == `STSR_POS_CONN) ? conn_b : 8'h00;
    wire [3:0] rec_n = pidx[0] ? rec_b[3:0] : rec_b[7:4];
    wire [3:0] err_n = err_ff[{~pidx[1:0], 2'b00} +: 4];
    wire [7:0] cur_b =
        (idx_ff == 6'h00) ? (nak_ff ? `STSR_NAK : `STSR_ACK) :
        (idx_ff == 6'h01) ? nib2hex(stn_ff[7:4]) :
        (idx_ff == 6'h02) ? nib2hex(stn_ff[3:0]) :
        (idx_ff == 6'h03) ? (lower_ff ? `STSR_CMD_LO : `STSR_CMD_UP) :
        (idx_ff == 6'h04) ? `STSR_TYPE_HI :
        (idx_ff == 6'h05) ? `STSR_TYPE_LO :
        (idx_ff < etx_idx) ? nib2hex(nak_ff ? err_n : rec_n) :
        (idx_ff == etx_idx) ? `STSR_ETX :
        (idx_ff == etx_idx + 6'h01) ? nib2hex(tx_sum[7:4]) : nib2hex(tx_sum[3:0]);
    wire load = tx_busy_ff & (~tx_valid_ff | tx_ready);

    assign tx_valid = tx_valid_ff;
    assign tx_data = tx_data_ff;

    // Sum of header through ETX; frozen while the checksum goes out
    stsr_cksum u_tx_cksum (
        .clock(clock),
        .rst_n(rst_n),
        .clr(reply_go),
        .add(load & (idx_ff <= etx_idx)),
        .byte_in(cur_b),
        .sum(tx_sum)
    );

    // Byte sequencer; the output register holds until taken
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tx_busy_ff <= 1'b0;
            nak_ff <= 1'b0;
            idx_ff <= 6'h00;
            tx_valid_ff <= 1'b0;
            tx_data_ff <= 8'h00;
            cnt_ff <= 16'h0000;
        end else if (reply_go) begin
            tx_busy_ff <= 1'b1;
            nak_ff <= nak_now;
            idx_ff <= 6'h00;
            cnt_ff <= cnt_ff + 16'h0001;
        end else if (load) begin
            tx_valid_ff <= 1'b1;
            tx_data_ff <= cur_b;
            idx_ff <= idx_ff + 6'h01;
            tx_busy_ff <= idx_ff != last_idx;
        end else if (tx_ready) begin
            tx_valid_ff <= 1'b0;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    AST_FOREIGN_SILENT: assert property (rx_eof && !stn_ok_ff |=> !tx_busy_ff)
        else $error("reply started for a foreign station");
    AST_ACK_FIRST: assert property (reply_go && !nak_now |=> ##1 tx_valid && tx_data == `STSR_ACK)
        else $error("ACK reply did not open with ACK");
    AST_NAK_FIRST: assert property (reply_go && nak_now |=> ##1 tx_valid && tx_data == `STSR_NAK)
        else $error("NAK reply did not open with NAK");
    AST_BAD_SUM_NAK: assert property (rx_eof && lower_ff && !sum_ok && stn_ok_ff &&
        ctrl_ff[`STSR_CTRL_EN]
        |=> nak_ff)
        else $error("bad request checksum not answered with NAK");
    AST_CK_HI: assert property (load && idx_ff == etx_idx + 6'h01
        |=> tx_data == nib2hex($past(tx_sum[7:4])))
        else $error("checksum high char wrong");
    AST_ETX_POS: assert property (load && idx_ff == etx_idx |=> tx_data == `STSR_ETX)
        else $error("ETX not at its position");
    AST_MODE_ONEHOT: assert property ($onehot(mode_b) && mode_b[7:5] == 3'h0 && !mode_b[0])
        else $error("mode byte not one-hot in bits 1 to 4");
    AST_CONN_BITS: assert property (conn_b[7:2] == 6'h00)
        else $error("connection byte uses upper bits");
    AST_UPPER_END: assert property (load && idx_ff == etx_idx && !lower_ff |=> !tx_busy_ff)
        else $error("uppercase reply ran past ETX");
    AST_BUS_ANSWER: assert property (req |-> ##[0:1] !avs_waitrequest)
        else $error("bus access not answered in one wait cycle");

    COV_ACK: cover property (reply_go && !nak_now);
    COV_NAK: cover property (reply_go && nak_now);
    COV_LOWER: cover property (load && idx_ff == last_idx && lower_ff);
    COV_FOREIGN: cover property (rx_eof && !stn_ok_ff);
endmodule : stsr_top

`default_nettype wire

// File: dv/stsr_host.sv
// Host model: sends request bytes to the handler and collects its replies.
// Assumes valid/ready byte handshakes on the handler's single clock.
`default_nettype none

module stsr_host (
    // Clock
    input wire logic clock,
    // Request bytes towards the handler
    output logic rx_valid,
    output logic [7:0] rx_data,
    input wire logic rx_ready,
    // Reply bytes from the handler
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic slow = 1'b0; // Stall the sink every other cycle
    logic [7:0] got[$]; // Reply bytes in arrival order
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
    end
    // Sink takes a byte on valid and ready; slow mode halves its rate
    // Sole driver of the sink's ready; it comes up high at the first edge
    always @(posedge clock) begin
        if (tx_valid && tx_ready) got.push_back(tx_data);
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end
    // One request byte, held until the handler takes it
    task automatic send(input logic [7:0] b);
        int n;
        n = 0;
        rx_valid <= 1'b1;
        rx_data <= b;
        do begin
            @(posedge clock);
            n++;
        end while (rx_ready !== 1'b1 && n < 400);
    endtask : send
    // Released line shows the inverse, never a stale byte
    task automatic idle();
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
    endtask : idle
endmodule : stsr_host

`default_nettype wire

// File: dv/stsr_tb_top.sv
// Testbench: register setup over Avalon-MM, request frames, reply checks.
// Assumes the handler top and the host model on one 250 MHz clock.
`include "stsr_cfg.svh"
`default_nettype none

module stsr_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] CPU = 8'h5A; // Arbitrary type code
    localparam logic [7:0] VER = 8'h12; // Version 1.2
    logic clock, nrst, avs_read, avs_write, avs_waitrequest;
    logic rx_valid, rx_ready, tx_valid, tx_ready;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0] avs_byteenable;
    logic [7:0] rx_data, tx_data;
    logic [7:0] rqq[$]; // Request frame
    logic [7:0] exq[$]; // Expected reply
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;

    stsr_top #(.CPU_TYPE_RST(CPU), .VER_RST(VER)) i_stsr_top (.clock(clock), .nrst(nrst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
    stsr_host i_stsr_host (.clock(clock), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // Hang guard: the tests need under a thousand cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            $display("mismatch at %0t: timeout", $time);
            wrap_up();
        end
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    task automatic chk_word(input logic [31:0] g, input logic [31:0] e, input string m);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk_word
    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e, input string m);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch at %0t: %s byte %h exp %h", $time, m, g, e);
        end
    endtask : chk_byte
    // One Avalon access, held until waitrequest is seen low; read data lands in rd
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0);
        chk_word(n, 32'h0000_0002, "bus answer");
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clock);
    endtask : bus
    // Upper-case ASCII hex, high nibble first
    task automatic push_hex(ref logic [7:0] q[$], input logic [7:0] b);
        q.push_back(b[7:4] < 4'hA ? 8'h30 + b[7:4] : 8'h37 + b[7:4]);
        q.push_back(b[3:0] < 4'hA ? 8'h30 + b[3:0] : 8'h37 + b[3:0]);
    endtask : push_hex
    // Header shared by requests and replies
    task automatic head(ref logic [7:0] q[$], input logic [7:0] c, input logic [7:0] s,
                        input logic lo);
        q = {c};
        push_hex(q, s);
        q.push_back(lo ? `STSR_CMD_LO : `STSR_CMD_UP);
        q.push_back(`STSR_TYPE_HI);
        q.push_back(`STSR_TYPE_LO);
    endtask : head
    // Low byte of the sum over the whole queue
    function automatic logic [7:0] sum8(input logic [7:0] q[$]);
        logic [7:0] s;
        s = 8'h00;
        foreach (q[i]) s += q[i];
        return s;
    endfunction : sum8
    task automatic req(input logic [7:0] stn, input logic lo, input logic [7:0] bad);
        head(rqq, `STSR_ENQ, stn, lo);
        rqq.push_back(`STSR_EOT);
        if (lo) push_hex(rqq, sum8(rqq) + bad);
    endtask : req
    task automatic rep(input logic lo, input logic ack, input logic [15:0] er,
                       input logic [1:0] m);
        head(exq, ack ? `STSR_ACK : `STSR_NAK, 8'h1A, lo);
        if (ack) begin
            for (int i = 0; i < 20; i++) begin
                push_hex(exq, i == 2 ? CPU : i == 4 ? VER : i == 5 ? 8'h01 << (m + 1) :
                         i == 7 ? {6'h00, m} : 8'h00);
            end
        end else begin
            push_hex(exq, er[15:8]);
            push_hex(exq, er[7:0]);
        end
        exq.push_back(`STSR_ETX);
        if (lo) push_hex(exq, sum8(exq));
    endtask : rep
    // Sends rqq, waits for the reply and compares it with exq byte by byte
    task automatic xfer(input logic sl, input string m);
        int n;
        n = 0;
        i_stsr_host.slow = sl;
        i_stsr_host.got.delete();
        foreach (rqq[k]) i_stsr_host.send(rqq[k]);
        i_stsr_host.idle();
        while (i_stsr_host.got.size() < exq.size() && n < 400) begin
            @(posedge clock);
            n++;
        end
        repeat (exq.size() == 0 ? 100 : 12) @(posedge clock);
        chk_word(i_stsr_host.got.size(), exq.size(), m);
        foreach (exq[k]) if (k < i_stsr_host.got.size()) chk_byte(i_stsr_host.got[k], exq[k], m);
        $display("test %s done", m);
    endtask : xfer

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        nrst = 1'b0;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hF;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        repeat (4) @(posedge clock);
        bus(1'b0, `STSR_OFS_CTRL, 32'h0);
        chk_word(rd, 32'h0000_0001, "ctrl reset");
        bus(1'b0, `STSR_OFS_INFO, 32'h0);
        chk_word(rd, {16'h0000, VER, CPU}, "info reset");
        bus(1'b1, 5'h18, 32'hFFFF_FFFF);
        bus(1'b0, 5'h18, 32'h0);
        chk_word(rd, 32'h0000_0000, "unmapped");
        $display("test registers done");
        bus(1'b1, `STSR_OFS_STN, 32'h0000_001A);
        // Every mode and connection code, both cases, fast and stalling sink
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, `STSR_OFS_MODE, {22'h0, m[1:0], 6'h00, m[1:0]});
            req(8'h1A, m[0], 8'h00);
            rep(m[0], 1'b1, 16'h0000, m[1:0]);
            xfer(m[1], "ack");
        end
        bus(1'b1, `STSR_OFS_ERR, 32'h0000_1132);
        bus(1'b1, `STSR_OFS_CTRL, 32'h0000_0003);
        for (int l = 0; l < 2; l++) begin
            req(8'h1A, l[0], 8'h00);
            rep(l[0], 1'b0, 16'h1132, 2'h0);
            xfer(l[0], "nak");
        end
        bus(1'b1, `STSR_OFS_CTRL, 32'h0000_0001);
        req(8'h1A, 1'b1, 8'h01);
        rep(1'b1, 1'b0, 16'h1132, 2'h0);
        xfer(1'b0, "bad checksum");
        req(8'h1B, 1'b0, 8'h00);
        exq.delete();
        xfer(1'b0, "foreign station");
        bus(1'b1, `STSR_OFS_CTRL, 32'h0000_0000);
        req(8'h1A, 1'b0, 8'h00);
        xfer(1'b0, "disabled");
        bus(1'b0, `STSR_OFS_STAT, 32'h0);
        chk_word(rd, 32'h0000_0007, "reply count");
        $display("test status done");
        wrap_up();
    end
endmodule : stsr_tb_top

`default_nettype wire
